/* core/typec_cc_config_registers.sv */
`timescale 1ns/1ps
module typec_cc_config_registers #(
    parameter int unsigned DEB_CYC_00 = cc_cfg_pkg::DEB00_MS
        * (cc_cfg_pkg::NS_PER_MS / cc_cfg_pkg::CLK_PERIOD_NS),
    parameter int unsigned DEB_CYC_01 = cc_cfg_pkg::DEB01_MS
        * (cc_cfg_pkg::NS_PER_MS / cc_cfg_pkg::CLK_PERIOD_NS),
    parameter int unsigned DEB_CYC_10 = cc_cfg_pkg::DEB10_MS
        * (cc_cfg_pkg::NS_PER_MS / cc_cfg_pkg::CLK_PERIOD_NS),
    parameter int unsigned DEB_CYC_11 = cc_cfg_pkg::DEB11_MS
        * (cc_cfg_pkg::NS_PER_MS / cc_cfg_pkg::CLK_PERIOD_NS),
    parameter logic [1:0] RSV45_INIT = cc_cfg_pkg::RSV45_RST
) (
    input wire logic CLK, // System clock
    input wire logic RST_N, // Async reset, active low
    input wire logic CE, // Clock enable
    input wire logic SCL_I, // Serial clock level
    input wire logic SDA_I, // Serial data level
    output logic SDA_OE_N, // Pull data low when 0
    output logic SDA_O, // Data drive value, always 0
    input wire logic ADDR_HI, // Address pin sensed high
    input wire logic ADDR_LO, // Address pin sensed low
    input wire logic PORT_HI, // Port pin sensed high
    input wire logic PORT_LO, // Port pin sensed low
    input wire logic CC_UNATTACHED, // CC machine is unattached
    input wire logic [6:0] STATUS_IN, // Status bits 7:1 of status_and_duty_config
    output logic I2C_MODE, // Serial control mode
    output logic [1:0] ROLE_MODE, // 01 sink, 10 source, 11 dual
    output logic ROLE_LOAD, // Pulse: restart CC machine in role
    output logic TRY_SNK, // Dual-role Try.SNK active
    output logic SINK_ACC_OFF, // Sink accessory support off
    output logic [24:0] DEBOUNCE_CYCLES, // CC filter length
    output logic TERM_OFF, // Terminations off, CC machine disabled
    output logic PULLS_OFF, // Pull-down and pull-up off
    output logic SOFT_RST // Reset to CC logic and status
);
    function automatic logic [24:0] deb_cycles(input logic [1:0] code);
        case (code)
            2'h0: deb_cycles = 25'(DEB_CYC_00);
            2'h1: deb_cycles = 25'(DEB_CYC_01);
            2'h2: deb_cycles = 25'(DEB_CYC_10);
            default: deb_cycles = 25'(DEB_CYC_11);
        endcase
    endfunction

    logic sink_acc_off_reg, term_off_reg, pulls_off_reg, srst_reg;
    logic [1:0] deb_reg, mode_reg, pref_reg, rsv45_reg, role_reg;
    logic [2:0] srst_cnt_reg;
    logic [7:0] wr_ptr_reg, rd_ptr_reg, rd_data_reg, rd_data_next;
    logic [24:0] deb_cyc_reg;
    logic [1:0] role_next;
    logic wr_stb, wr_first, rd_take;
    logic [7:0] wr_byte;

    wire i2c_mode = ADDR_HI ^ ADDR_LO;
    wire [6:0] dev_addr = ADDR_HI ? cc_cfg_pkg::DEV_ADDR_HI
        : cc_cfg_pkg::DEV_ADDR_LO;
    wire data_wr = wr_stb & ~wr_first;
    wire wr_09 = data_wr & (wr_ptr_reg == cc_cfg_pkg::REG_STAT_DUTY);
    wire wr_0a = data_wr & (wr_ptr_reg == cc_cfg_pkg::REG_CC_CTRL);
    wire wr_45 = data_wr & (wr_ptr_reg == cc_cfg_pkg::REG_TERM_OVR);
    wire srst_set = wr_0a & wr_byte[cc_cfg_pkg::SRST_BIT];
    wire mode_wr = wr_0a & CC_UNATTACHED;
    wire [1:0] pin_role = PORT_HI ? cc_cfg_pkg::ROLE_SRC
        : PORT_LO ? cc_cfg_pkg::ROLE_SNK : cc_cfg_pkg::ROLE_DRP;
    wire use_override = i2c_mode & (mode_reg != cc_cfg_pkg::ROLE_PIN);

    assign role_next = use_override ? mode_reg : pin_role;
    assign SDA_O = 1'b0;
    assign I2C_MODE = i2c_mode;
    assign ROLE_MODE = role_reg;
    assign SINK_ACC_OFF = sink_acc_off_reg;
    assign DEBOUNCE_CYCLES = deb_cyc_reg;
    assign TERM_OFF = term_off_reg;
    assign PULLS_OFF = pulls_off_reg;
    assign SOFT_RST = srst_reg;

    always_comb begin
        case (rd_ptr_reg)
            cc_cfg_pkg::REG_STAT_DUTY: rd_data_next = {STATUS_IN, sink_acc_off_reg};
            cc_cfg_pkg::REG_CC_CTRL: rd_data_next = {deb_reg, mode_reg, srst_reg,
                pref_reg, term_off_reg};
            cc_cfg_pkg::REG_TERM_OVR: rd_data_next = {5'h00, pulls_off_reg, rsv45_reg};
            default: rd_data_next = 8'h00;
        endcase
    end

    i2c_reg_port port_u (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .scl(SCL_I),
        .sda(SDA_I),
        .enable(i2c_mode),
        .busy(srst_reg),
        .dev_addr(dev_addr),
        .rd_data(rd_data_reg),
        .sda_oe_n(SDA_OE_N),
        .wr_stb(wr_stb),
        .wr_first(wr_first),
        .wr_byte(wr_byte),
        .rd_take(rd_take)
    );

    // Index byte sets both pointers; data and reads step their own
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_ptr_reg <= cc_cfg_pkg::PTR_RST;
            rd_ptr_reg <= cc_cfg_pkg::PTR_RST;
            rd_data_reg <= 8'h00;
        end else if (CE) begin
            rd_data_reg <= rd_data_next;
            if (wr_stb && wr_first) begin
                wr_ptr_reg <= wr_byte;
                rd_ptr_reg <= wr_byte;
            end else if (data_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 8'h01;
            end else if (rd_take) begin
                rd_ptr_reg <= rd_ptr_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sink_acc_off_reg <= cc_cfg_pkg::ACC_OFF_RST;
            deb_reg <= cc_cfg_pkg::DEB_RST;
            mode_reg <= cc_cfg_pkg::MODE_RST;
            pref_reg <= cc_cfg_pkg::PREF_RST;
            term_off_reg <= cc_cfg_pkg::TERM_OFF_RST;
            pulls_off_reg <= cc_cfg_pkg::PULLS_OFF_RST;
            rsv45_reg <= RSV45_INIT;
        end else if (CE) begin
            if (wr_09) begin
                sink_acc_off_reg <= wr_byte[cc_cfg_pkg::ACC_OFF_BIT];
            end
            if (wr_0a) begin
                deb_reg <= wr_byte[cc_cfg_pkg::DEB_LSB +: 2];
                pref_reg <= wr_byte[cc_cfg_pkg::PREF_LSB +: 2];
                term_off_reg <= wr_byte[cc_cfg_pkg::TERM_OFF_BIT];
            end
            if (mode_wr) begin
                mode_reg <= wr_byte[cc_cfg_pkg::MODE_LSB +: 2];
            end
            if (wr_45) begin
                pulls_off_reg <= wr_byte[cc_cfg_pkg::PULLS_OFF_BIT];
                rsv45_reg <= wr_byte[cc_cfg_pkg::RSV45_LSB +: 2];
            end
        end
    end

    // Soft reset pulse; a new request reloads the count
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            srst_reg <= 1'b0;
            srst_cnt_reg <= 3'h0;
        end else if (CE) begin
            if (srst_set) begin
                srst_reg <= 1'b1;
                srst_cnt_reg <= cc_cfg_pkg::SRST_LOAD;
            end else if (srst_reg && srst_cnt_reg == 3'h0) begin
                srst_reg <= 1'b0;
            end else if (srst_reg) begin
                srst_cnt_reg <= srst_cnt_reg - 3'h1;
            end
        end
    end

    // Role restarts the CC machine whenever it changes
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            role_reg <= cc_cfg_pkg::ROLE_DRP;
            ROLE_LOAD <= 1'b0;
            TRY_SNK <= 1'b0;
            deb_cyc_reg <= 25'h0000000;
        end else if (CE) begin
            role_reg <= role_next;
            ROLE_LOAD <= (role_next != role_reg) | srst_set;
            TRY_SNK <= (role_next == cc_cfg_pkg::ROLE_DRP)
                & (pref_reg == cc_cfg_pkg::PREF_TRY_SNK);
            deb_cyc_reg <= deb_cycles(deb_reg);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N || !CE);

    sequence srst_run;
        SOFT_RST [*4];
    endsequence
    sequence srst_end;
        !SOFT_RST;
    endsequence

    a_acc_off_write: assert property (wr_09 ##1 CE |->
        SINK_ACC_OFF == $past(wr_byte[0]))
        else $error("sink accessory bit not stored");
    a_deb_select: assert property ((deb_reg == 2'h1) ##1 CE |->
        DEBOUNCE_CYCLES == 25'(DEB_CYC_01))
        else $error("debounce count wrong for code 01");
    a_mode_force: assert property ((i2c_mode && mode_reg == 2'h2) ##1 CE |->
        ROLE_MODE == 2'h2)
        else $error("source override not applied");
    a_port_drp: assert property ((!use_override && !PORT_HI && !PORT_LO)
        ##1 CE |-> ROLE_MODE == 2'h3)
        else $error("open port pin not dual-role");
    a_mode_locked: assert property (!CC_UNATTACHED ##1 CE |->
        mode_reg == $past(mode_reg))
        else $error("override changed while attached");
    a_srst_pulse: assert property ($rose(SOFT_RST) |-> srst_run)
        else $error("soft reset shorter than four cycles");
    a_srst_bound: assert property ((SOFT_RST && srst_cnt_reg == 3'h0 && !srst_set)
        ##1 CE |-> srst_end)
        else $error("soft reset not self-cleared");
    // Only the ack of the request byte may pull data low as the pulse starts
    a_srst_refuse: assert property (SOFT_RST && $past(SOFT_RST) |-> !$fell(SDA_OE_N))
        else $error("address acknowledged during soft reset");
    a_try_snk: assert property (TRY_SNK |->
        $past(pref_reg) == 2'h1 && ROLE_MODE == 2'h3)
        else $error("Try.SNK outside dual-role preference");
    a_term_off: assert property (wr_0a ##1 CE |->
        TERM_OFF == $past(wr_byte[0]))
        else $error("termination bit not stored");
    a_pulls_off: assert property (wr_45 ##1 CE |->
        PULLS_OFF == $past(wr_byte[2]))
        else $error("pull disable bit not stored");
    a_rd_step: assert property (rd_take && !(wr_stb && wr_first) ##1 CE |->
        rd_ptr_reg == $past(rd_ptr_reg) + 8'h01)
        else $error("read pointer did not advance");
endmodule // typec_cc_config_registers

/* common/cc_cfg_pkg.sv */
package cc_cfg_pkg;
    // Register indices on the serial port
    localparam logic [7:0] REG_STAT_DUTY = 8'h09;
    localparam logic [7:0] REG_CC_CTRL = 8'h0a;
    localparam logic [7:0] REG_TERM_OVR = 8'h45;
    // Field positions
    localparam int ACC_OFF_BIT = 0;
    localparam int DEB_LSB = 6;
    localparam int MODE_LSB = 4;
    localparam int SRST_BIT = 3;
    localparam int PREF_LSB = 1;
    localparam int TERM_OFF_BIT = 0;
    localparam int PULLS_OFF_BIT = 2;
    localparam int RSV45_LSB = 0;
    // Reset values
    localparam logic ACC_OFF_RST = 1'b0;
    localparam logic [1:0] DEB_RST = 2'h0;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [1:0] PREF_RST = 2'h0;
    localparam logic TERM_OFF_RST = 1'b0;
    localparam logic PULLS_OFF_RST = 1'b0;
    localparam logic [1:0] RSV45_RST = 2'h0;
    localparam logic [7:0] PTR_RST = 8'h00;
    // Role codes, shared by the override field and the role output
    localparam logic [1:0] ROLE_PIN = 2'h0;
    localparam logic [1:0] ROLE_SNK = 2'h1;
    localparam logic [1:0] ROLE_SRC = 2'h2;
    localparam logic [1:0] ROLE_DRP = 2'h3;
    localparam logic [1:0] PREF_TRY_SNK = 2'h1;
    // Serial addresses for the two strap levels
    localparam logic [6:0] DEV_ADDR_LO = 7'h47;
    localparam logic [6:0] DEV_ADDR_HI = 7'h67;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_MS = 1000000;
    localparam int DEB00_MS = 168;
    localparam int DEB01_MS = 118;
    localparam int DEB10_MS = 134;
    localparam int DEB11_MS = 152;
    localparam int DEB_W = 25;
    localparam int SRST_CYC = 4;
    localparam logic [2:0] SRST_LOAD = 3'(SRST_CYC - 1);
endpackage

/* core/i2c_reg_port.sv */
`timescale 1ns/1ps
module i2c_reg_port (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic scl, // Serial clock level
    input wire logic sda, // Serial data level
    input wire logic enable, // Serial control mode active
    input wire logic busy, // Refuse new transactions
    input wire logic [6:0] dev_addr, // Own 7-bit address
    input wire logic [7:0] rd_data, // Byte to send next
    output logic sda_oe_n, // Data pulled low when 0
    output logic wr_stb, // Received byte pulse
    output logic wr_first, // Received byte is the index
    output logic [7:0] wr_byte, // Received byte
    output logic rd_take // Read byte loaded pulse
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_AACK = 3'b010,
        S_WBYTE = 3'b011,
        S_WACK = 3'b100,
        S_RBYTE = 3'b101,
        S_RACK = 3'b110
    } bus_state_e;

    bus_state_e state_reg, state_next;
    logic scl_reg, sda_reg;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next;
    logic rw_reg, rw_next, first_reg, first_next, mack_reg, mack_next;

    wire start_cond = scl_reg & scl & sda_reg & ~sda;
    wire stop_cond = scl_reg & scl & ~sda_reg & sda;
    wire rise = ~scl_reg & scl;
    wire fall = scl_reg & ~scl;
    wire full = cnt_reg == 4'd8;
    // Busy keeps the address unacknowledged during soft reset
    wire addr_hit = enable & ~busy & (sh_reg[7:1] == dev_addr);
    wire drive = (state_reg == S_AACK) | (state_reg == S_WACK)
        | ((state_reg == S_RBYTE) & ~sh_reg[7]);

    assign sda_oe_n = ~drive;
    assign wr_byte = sh_reg;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        rw_next = rw_reg;
        first_next = first_reg;
        mack_next = mack_reg;
        wr_stb = 1'b0;
        wr_first = 1'b0;
        rd_take = 1'b0;
        case (state_reg)
            S_IDLE: begin
            end
            S_ADDR, S_WBYTE: begin
                if (rise) begin
                    sh_next = {sh_reg[6:0], sda};
                    cnt_next = cnt_reg + 4'd1;
                end
                if (fall && full && state_reg == S_ADDR) begin
                    state_next = addr_hit ? S_AACK : S_IDLE;
                    rw_next = sh_reg[0];
                end
                if (fall && full && state_reg == S_WBYTE) begin
                    state_next = S_WACK;
                    wr_stb = 1'b1;
                    wr_first = first_reg;
                    first_next = 1'b0;
                end
            end
            S_AACK: begin
                if (fall) begin
                    cnt_next = 4'd0;
                    first_next = 1'b1;
                    if (rw_reg) begin
                        state_next = S_RBYTE;
                        sh_next = rd_data;
                        rd_take = 1'b1;
                    end else begin
                        state_next = S_WBYTE;
                    end
                end
            end
            S_WACK: begin
                if (fall) begin
                    state_next = S_WBYTE;
                    cnt_next = 4'd0;
                end
            end
            S_RBYTE: begin
                if (fall && cnt_reg == 4'd7) begin
                    state_next = S_RACK;
                    cnt_next = 4'd0;
                end else if (fall) begin
                    sh_next = {sh_reg[6:0], 1'b0};
                    cnt_next = cnt_reg + 4'd1;
                end
            end
            S_RACK: begin
                if (rise) begin
                    mack_next = ~sda;
                end
                if (fall && mack_reg) begin
                    state_next = S_RBYTE;
                    sh_next = rd_data;
                    rd_take = 1'b1;
                end else if (fall) begin
                    state_next = S_IDLE;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
        if (start_cond) begin
            state_next = S_ADDR;
            cnt_next = 4'd0;
        end else if (stop_cond) begin
            state_next = S_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_IDLE;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            cnt_reg <= 4'd0;
            sh_reg <= 8'h00;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            mack_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            scl_reg <= scl;
            sda_reg <= sda;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            rw_reg <= rw_next;
            first_reg <= first_next;
            mack_reg <= mack_next;
        end
    end
endmodule // i2c_reg_port

/* sim/i2c_host_model.sv */
`timescale 1ns/1ps
module i2c_host_model (
    input wire logic clk, // System clock
    input wire logic sda_line, // Resolved data wire
    output logic scl, // Serial clock
    output logic sda_drv // Data drive, 1 = released
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Each phase lasts 4 system clocks
    task automatic tick;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic put_bit(input logic b);
        sda_drv = b;
        tick();
        scl = 1'b1;
        tick();
        scl = 1'b0;
        tick();
    endtask
    task automatic get_bit(output logic b);
        sda_drv = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        b = sda_line;
        scl = 1'b0;
        tick();
    endtask
    task automatic start_cond;
        sda_drv = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda_drv = 1'b0;
        tick();
        scl = 1'b0;
        tick();
    endtask
    task automatic stop_cond;
        sda_drv = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda_drv = 1'b1;
        tick();
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(b);
        ack = ~b;
    endtask
    task automatic recv_byte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(last);
    endtask
    // Index byte first, then data
    task automatic write_reg(input logic [6:0] a, input logic [7:0] idx,
        input logic [7:0] d, output logic ack);
        logic k;
        start_cond();
        send_byte({a, 1'b0}, ack);
        send_byte(idx, k);
        send_byte(d, k);
        stop_cond();
    endtask
    // Set pointer, then read two bytes in a row
    task automatic read_reg(input logic [6:0] a, input logic [7:0] idx,
        output logic [7:0] d0, output logic [7:0] d1, output logic ack);
        logic k;
        start_cond();
        send_byte({a, 1'b0}, ack);
        send_byte(idx, k);
        start_cond();
        send_byte({a, 1'b1}, k);
        recv_byte(d0, 1'b0);
        recv_byte(d1, 1'b1);
        stop_cond();
    endtask
endmodule // i2c_host_model

/* sim/tb_typec_cc_config_registers.sv */
`timescale 1ns/1ps
module tb_typec_cc_config_registers;
    logic clk, rst_n, ce, addr_hi, addr_lo, port_hi, port_lo, cc_unattached;
    logic [6:0] status_in;
    logic [6:0] dev_a;
    logic scl, sda_drv, sda_line, sda_oe_n, sda_o, i2c_mode, role_load;
    logic try_snk, sink_acc_off, term_off, pulls_off, soft_rst;
    logic [1:0] role_mode;
    logic [24:0] debounce_cycles;
    int err_count, n_checks, loads, srst_cyc;
    assign sda_line = sda_drv & (sda_oe_n | sda_o);
    typec_cc_config_registers #(.DEB_CYC_00(100), .DEB_CYC_01(110), .DEB_CYC_10(120),
        .DEB_CYC_11(130)) u_typec_cc_config_registers (
        .CLK(clk), .RST_N(rst_n), .CE(ce), .SCL_I(scl), .SDA_I(sda_line),
        .SDA_OE_N(sda_oe_n), .SDA_O(sda_o), .ADDR_HI(addr_hi), .ADDR_LO(addr_lo),
        .PORT_HI(port_hi), .PORT_LO(port_lo), .CC_UNATTACHED(cc_unattached),
        .STATUS_IN(status_in), .I2C_MODE(i2c_mode), .ROLE_MODE(role_mode),
        .ROLE_LOAD(role_load), .TRY_SNK(try_snk), .SINK_ACC_OFF(sink_acc_off),
        .DEBOUNCE_CYCLES(debounce_cycles), .TERM_OFF(term_off), .PULLS_OFF(pulls_off),
        .SOFT_RST(soft_rst));
    i2c_host_model u_i2c_host_model (.clk(clk), .sda_line(sda_line), .scl(scl),
        .sda_drv(sda_drv));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (role_load === 1'b1) loads++;
        if (soft_rst === 1'b1) srst_cyc++;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [24:0] got, input logic [24:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic ack;
        u_i2c_host_model.write_reg(dev_a, idx, d, ack);
        chk(25'(ack), 25'h1);
        step(2);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e0, input logic [7:0] e1);
        logic ack;
        logic [7:0] d0, d1;
        u_i2c_host_model.read_reg(dev_a, idx, d0, d1, ack);
        chk(25'(ack), 25'h1);
        chk(25'(d0), 25'(e0));
        chk(25'(d1), 25'(e1));
    endtask
    task automatic try_addr(input logic [6:0] a, input logic exp);
        logic ack;
        u_i2c_host_model.write_reg(a, 8'h45, 8'h00, ack);
        chk(25'(ack), 25'(exp));
    endtask
    task automatic t_reset;
        chk(25'(role_mode), 25'(cc_cfg_pkg::ROLE_DRP));
        chk(debounce_cycles, 25'd100);
        chk(25'({sink_acc_off, term_off, pulls_off, try_snk}), 25'h0);
        rd(8'h09, {status_in, 1'b0}, 8'h00);
        rd(8'h45, 8'h00, 8'h00);
    endtask
    task automatic t_addr;
        try_addr(7'h67, 1'b0);
        {addr_hi, addr_lo} = 2'b10;
        step(2);
        chk(25'(i2c_mode), 25'h1);
        try_addr(7'h67, 1'b1);
        try_addr(7'h47, 1'b0);
        for (int p = 0; p < 4; p += 3) begin
            {addr_hi, addr_lo} = 2'(p);
            step(2);
            chk(25'(i2c_mode), 25'h0);
            try_addr(7'h47, 1'b0);
        end
        {addr_hi, addr_lo} = 2'b01;
        step(2);
    endtask
    task automatic t_debounce;
        logic [24:0] tbl [4];
        tbl = '{25'd100, 25'd110, 25'd120, 25'd130};
        for (int c = 0; c < 4; c++) begin
            wr(8'h0a, 8'(c << 6));
            chk(debounce_cycles, tbl[c]);
        end
        wr(8'h09, 8'h01);
        chk(25'(sink_acc_off), 25'h1);
        rd(8'h09, {status_in, 1'b1}, 8'hc0);
        wr(8'h09, 8'h00);
        chk(25'(sink_acc_off), 25'h0);
    endtask
    task automatic t_role;
        int l0;
        for (int m = 1; m < 4; m++) begin
            l0 = loads;
            wr(8'h0a, 8'(m << 4));
            chk(25'(role_mode), 25'(m));
            chk(25'(loads - l0), 25'h1);
        end
        wr(8'h0a, 8'h32);
        chk(25'(try_snk), 25'h1);
        wr(8'h0a, 8'h12);
        chk(25'(try_snk), 25'h0);
        wr(8'h0a, 8'h00);
        {port_hi, port_lo} = 2'b01;
        step(3);
        chk(25'(role_mode), 25'(cc_cfg_pkg::ROLE_SNK));
        {port_hi, port_lo} = 2'b10;
        step(3);
        chk(25'(role_mode), 25'(cc_cfg_pkg::ROLE_SRC));
        ce = 1'b0;
        {port_hi, port_lo} = 2'b01;
        step(3);
        chk(25'(role_mode), 25'(cc_cfg_pkg::ROLE_SRC));
        ce = 1'b1;
        step(3);
        chk(25'(role_mode), 25'(cc_cfg_pkg::ROLE_SNK));
        {port_hi, port_lo} = 2'b00;
        step(3);
        cc_unattached = 1'b0;
        wr(8'h0a, 8'h21);
        chk(25'(role_mode), 25'(cc_cfg_pkg::ROLE_DRP));
        chk(25'(term_off), 25'h1);
        rd(8'h0a, 8'h01, 8'h00);
        cc_unattached = 1'b1;
        wr(8'h0a, 8'h00);
        chk(25'(term_off), 25'h0);
    endtask
    task automatic t_pulls;
        wr(8'h45, 8'h04);
        chk(25'(pulls_off), 25'h1);
        wr(8'h45, 8'hfc);
        rd(8'h45, 8'h04, 8'h00);
        wr(8'h45, 8'h00);
        chk(25'(pulls_off), 25'h0);
    endtask
    task automatic t_srst;
        int c0, l0;
        c0 = srst_cyc;
        l0 = loads;
        wr(8'h0a, 8'h08);
        step(10);
        chk(25'(srst_cyc - c0), 25'(cc_cfg_pkg::SRST_CYC));
        chk(25'(loads > l0), 25'h1);
        rd(8'h0a, 8'h00, 8'h00);
        c0 = srst_cyc;
        wr(8'h0a, 8'h00);
        step(10);
        chk(25'(srst_cyc - c0), 25'h0);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        {addr_hi, addr_lo} = 2'b01;
        {port_hi, port_lo} = 2'b00;
        cc_unattached = 1'b1;
        status_in = 7'h55;
        dev_a = cc_cfg_pkg::DEV_ADDR_LO;
        err_count = 0;
        n_checks = 0;
        loads = 0;
        srst_cyc = 0;
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        step(3);
        t_reset();
        t_addr();
        t_debounce();
        t_role();
        t_pulls();
        t_srst();
        test_done();
    end
    initial begin
        #500000;
        err_count++;
        test_done();
    end
endmodule // tb_typec_cc_config_registers
